// [core/wkh_pkg.sv]
// Shared constants, register map and types of the wake and detect sequencer.
package wkh_pkg;

  // ------
  // Clock and timing
  // ------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_XFER_NS     = 2000;    // Status copy settle time.
  localparam int T_ARM_NS      = 100000;  // Wait before detection is started.
  localparam int CYC_XFER      = (T_XFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_ARM       = (T_ARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 24;

  // ------
  // Device register map
  // ------
  localparam logic [15:0] MASTER_CLOCK_CONTROL       = 16'h1009;
  localparam logic [15:0] POWER_DOWN_CONTROL_ONE     = 16'h1101;
  localparam logic [15:0] POWER_DOWN_CONTROL_TWO     = 16'h1102;
  localparam logic [15:0] HEADSET_DETECT_CONTROL_TWO = 16'h1120;
  localparam logic [15:0] CODEC_EVENT_STATUS         = 16'h1308;
  localparam logic [15:0] DETECT_EVENT_STATUS_ONE    = 16'h1309;
  localparam logic [15:0] DETECT_EVENT_STATUS_TWO    = 16'h130A;
  localparam logic [15:0] CODEC_EVENT_MASK           = 16'h131B;
  localparam logic [15:0] HEADSET_CLAMP_CONTROL      = 16'h1B70;
  localparam logic [15:0] WAKE_CONTROL               = 16'h1B71;
  localparam logic [15:0] MISC_DETECT_CONTROL        = 16'h1B74;
  localparam logic [15:0] MIC_DETECT_CONTROL_ONE     = 16'h1B75;
  localparam logic [15:0] CONVERTER_CONTROL_TWO      = 16'h1F06;

  // ------
  // Values written and fields read
  // ------
  localparam logic [7:0] VAL_CLAMP_OFF    = 8'h80;
  localparam logic [7:0] VAL_MCLK_ON      = 8'h00;
  localparam logic [7:0] VAL_WAKE_ARMED   = 8'hC0;
  localparam logic [7:0] VAL_WAKE_RELEASE = 8'hC1;
  localparam logic [7:0] VAL_MIC_COPY_IN  = 8'h5F;
  localparam logic [7:0] VAL_MIC_COPY_OUT = 8'h9F;
  localparam logic [7:0] VAL_PDN_ONE      = 8'hFE;
  localparam logic [7:0] VAL_PDN_TWO      = 8'h87;
  localparam logic [7:0] VAL_CONV_TWO     = 8'h86;
  localparam logic [7:0] VAL_MISC_DET     = 8'h07;
  localparam logic [7:0] VAL_EVENT_MASK   = 8'h01;
  localparam logic [7:0] VAL_DET_IDLE     = 8'h80;
  localparam logic [7:0] VAL_DET_RUN      = 8'hC0;
  localparam logic [7:0] VAL_NONE         = 8'h00;
  localparam int         PLUG_BIT         = 6;
  localparam int         UNPLUG_BIT       = 5;
  localparam int         AUTO_DONE_BIT    = 1;

  // ------
  // Software register map
  // ------
  localparam logic [3:0] SW_CONFIG = 4'h0;
  localparam logic [3:0] SW_CMD    = 4'h1;
  localparam logic [3:0] SW_STATUS = 4'h2;
  localparam logic [3:0] SW_STAT1  = 4'h3;
  localparam logic [3:0] SW_STAT2  = 4'h4;
  localparam int CFG_USE_WAKE = 0;
  localparam int CFG_USE_INT  = 1;
  localparam int CFG_ARMED    = 2;
  localparam int CMD_STANDBY  = 0;
  localparam int CMD_WAKE     = 1;

  // ------
  // Sequence program
  // ------
  typedef enum logic [2:0] {
    OP_WR, OP_RD, OP_WAIT, OP_PWR, OP_BRANCH, OP_POLL, OP_END
  } wkh_op_t;

  typedef enum logic [1:0] {
    W_REF, W_XFER, W_BIAS, W_ARM
  } wkh_wait_t;

  typedef struct packed {
    wkh_op_t     op;
    logic [15:0] addr;
    logic [7:0]  data;
  } wkh_step_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_FETCH = 3'h1,
    S_REQ   = 3'h3,
    S_TIMER = 3'h2,
    S_NEXT  = 3'h6
  } wkh_state_t;

  localparam logic [4:0] PC_STANDBY = 5'h00;
  localparam logic [4:0] PC_WAKE    = 5'h02;

endpackage : wkh_pkg

// [core/wkh_sequencer.sv]
// Host sequencer that prepares standby and walks the codec out of it.
//
// What the device needs and what this block does
// (R1) Device datapath needs 12/24 MHz bit clock.
// (R2) Device starts on bypass, moves after settling.
// (R3) Device synthesizer settles within 1 ms.
// (R4) Turn headset clamps off before standby.
// (R5) Start wake sequence on wake/interrupt pin.
// (R6) Apply supplies, reference, then master clock 0x00.
// (R7) Device rate is master clock over 250.
// (R8) Write wake control 0xC0, masks set.
// (R9) Release wake pin: write 0xC1 then 0xC0.
// (R10) Write mic detect 0x5F, wait 2 us.
// (R11) Read both status; continue only on plug.
// (R12) On plug write mic detect 0x9F.
// (R13) Write power down one 0xFE.
// (R14) Write power down two 0x87.
// (R15) Write converter control two 0x86.
// (R16) Write misc detect control 0x07.
// (R17) Wait bias startup plus ramp time.
// (R18) Write event mask 0x01.
// (R19) Write detect control 0x80, wait 100 us.
// (R20) Write detect control 0xC0, poll done.
// (R21) Steps strictly in order, waits honoured.
`timescale 1ns/1ps
`default_nettype none
module wkh_sequencer #(
  parameter int REF_WAIT_CYC  = 100,
  parameter int BIAS_WAIT_CYC = 10000,
  parameter int POLL_LIMIT    = 64
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Software register port.
  input  wire logic [3:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_write,
  input  wire logic        sw_read,
  output logic      [7:0]  sw_rdata,
  // Device control port.
  output logic             dev_req,
  output logic             dev_write,
  output logic      [15:0] dev_addr,
  output logic      [7:0]  dev_wdata,
  input  wire logic        dev_ack,
  input  wire logic [7:0]  dev_rdata,
  // Device pins and supplies.
  input  wire logic        wake_n,
  input  wire logic        irq_n,
  output logic             supply_en,
  output logic             ref_clock_en
);

  // ------
  // Checks and program table
  // ------
  initial begin
    if (REF_WAIT_CYC < 1 || BIAS_WAIT_CYC < 1 ||
        BIAS_WAIT_CYC >= (1 << wkh_pkg::TMR_W))
      $error("wkh_sequencer: wait count out of range");
    if (POLL_LIMIT < 1 || POLL_LIMIT > 255)
      $error("wkh_sequencer: poll limit out of range");
  end

  // One step of the program.
  function automatic wkh_pkg::wkh_step_t step_at(input logic [4:0] pc);
    wkh_pkg::wkh_step_t s;
    s = '{wkh_pkg::OP_END, 16'h0000, wkh_pkg::VAL_NONE};
    case (pc)
      5'h00: s = '{wkh_pkg::OP_WR, wkh_pkg::HEADSET_CLAMP_CONTROL,
                   wkh_pkg::VAL_CLAMP_OFF};                        // [R4]
      5'h01: s = '{wkh_pkg::OP_END, 16'h0000, wkh_pkg::VAL_NONE};
      5'h02: s = '{wkh_pkg::OP_PWR, 16'h0000, wkh_pkg::VAL_NONE}; // [R6]
      5'h03: s = '{wkh_pkg::OP_WAIT, 16'h0000, 8'(wkh_pkg::W_REF)};
      5'h04: s = '{wkh_pkg::OP_WR, wkh_pkg::MASTER_CLOCK_CONTROL,
                   wkh_pkg::VAL_MCLK_ON};                          // [R6]
      5'h05: s = '{wkh_pkg::OP_WR, wkh_pkg::WAKE_CONTROL,
                   wkh_pkg::VAL_WAKE_ARMED};                       // [R8]
      5'h06: s = '{wkh_pkg::OP_WR, wkh_pkg::MIC_DETECT_CONTROL_ONE,
                   wkh_pkg::VAL_MIC_COPY_IN};                      // [R10]
      5'h07: s = '{wkh_pkg::OP_WAIT, 16'h0000, 8'(wkh_pkg::W_XFER)}; // [R10]
      5'h08: s = '{wkh_pkg::OP_RD, wkh_pkg::DETECT_EVENT_STATUS_ONE,
                   wkh_pkg::VAL_NONE};                             // [R11]
      5'h09: s = '{wkh_pkg::OP_RD, wkh_pkg::DETECT_EVENT_STATUS_TWO,
                   wkh_pkg::VAL_NONE};                             // [R11]
      5'h0A: s = '{wkh_pkg::OP_WR, wkh_pkg::WAKE_CONTROL,
                   wkh_pkg::VAL_WAKE_RELEASE};                     // [R9]
      5'h0B: s = '{wkh_pkg::OP_WR, wkh_pkg::WAKE_CONTROL,
                   wkh_pkg::VAL_WAKE_ARMED};                       // [R9]
      5'h0C: s = '{wkh_pkg::OP_BRANCH, 16'h0000, wkh_pkg::VAL_NONE}; // [R11]
      5'h0D: s = '{wkh_pkg::OP_WR, wkh_pkg::MIC_DETECT_CONTROL_ONE,
                   wkh_pkg::VAL_MIC_COPY_OUT};                     // [R12]
      5'h0E: s = '{wkh_pkg::OP_WR, wkh_pkg::POWER_DOWN_CONTROL_ONE,
                   wkh_pkg::VAL_PDN_ONE};                          // [R13]
      5'h0F: s = '{wkh_pkg::OP_WR, wkh_pkg::POWER_DOWN_CONTROL_TWO,
                   wkh_pkg::VAL_PDN_TWO};                          // [R14]
      5'h10: s = '{wkh_pkg::OP_WR, wkh_pkg::CONVERTER_CONTROL_TWO,
                   wkh_pkg::VAL_CONV_TWO};                         // [R15]
      5'h11: s = '{wkh_pkg::OP_WR, wkh_pkg::MISC_DETECT_CONTROL,
                   wkh_pkg::VAL_MISC_DET};                         // [R16]
      5'h12: s = '{wkh_pkg::OP_WAIT, 16'h0000, 8'(wkh_pkg::W_BIAS)}; // [R17]
      5'h13: s = '{wkh_pkg::OP_WR, wkh_pkg::CODEC_EVENT_MASK,
                   wkh_pkg::VAL_EVENT_MASK};                       // [R18]
      5'h14: s = '{wkh_pkg::OP_WR, wkh_pkg::HEADSET_DETECT_CONTROL_TWO,
                   wkh_pkg::VAL_DET_IDLE};                         // [R19]
      5'h15: s = '{wkh_pkg::OP_WAIT, 16'h0000, 8'(wkh_pkg::W_ARM)}; // [R19]
      5'h16: s = '{wkh_pkg::OP_WR, wkh_pkg::HEADSET_DETECT_CONTROL_TWO,
                   wkh_pkg::VAL_DET_RUN};                          // [R20]
      5'h17: s = '{wkh_pkg::OP_POLL, wkh_pkg::CODEC_EVENT_STATUS,
                   wkh_pkg::VAL_NONE};                             // [R20]
      default: s = '{wkh_pkg::OP_END, 16'h0000, wkh_pkg::VAL_NONE};
    endcase
    return s;
  endfunction : step_at

  // Cycle count for each kind of wait.
  function automatic logic [wkh_pkg::TMR_W-1:0] wait_len(input logic [1:0] id);
    logic [wkh_pkg::TMR_W-1:0] n;
    n = wkh_pkg::TMR_W'(REF_WAIT_CYC);
    case (id)
      2'(wkh_pkg::W_REF):  n = wkh_pkg::TMR_W'(REF_WAIT_CYC);
      2'(wkh_pkg::W_XFER): n = wkh_pkg::TMR_W'(wkh_pkg::CYC_XFER);
      2'(wkh_pkg::W_BIAS): n = wkh_pkg::TMR_W'(BIAS_WAIT_CYC);
      2'(wkh_pkg::W_ARM):  n = wkh_pkg::TMR_W'(wkh_pkg::CYC_ARM);
      default:             n = wkh_pkg::TMR_W'(REF_WAIT_CYC);
    endcase
    return n;
  endfunction : wait_len

  // ------
  // Pin synchronisers
  // ------
  logic [2:0] wake_s_q;
  logic [2:0] irq_s_q;
  logic       wake_f_q;
  logic       irq_f_q;

  // Three stages; the filtered level moves once stages two and three agree.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_s_q <= 3'h7;
      irq_s_q  <= 3'h7;
      wake_f_q <= 1'b1;
      irq_f_q  <= 1'b1;
    end else begin
      wake_s_q <= {wake_s_q[1:0], wake_n};
      irq_s_q  <= {irq_s_q[1:0], irq_n};
      if (wake_s_q[1] == wake_s_q[2]) wake_f_q <= wake_s_q[2];
      if (irq_s_q[1] == irq_s_q[2])   irq_f_q  <= irq_s_q[2];
    end
  end

  // ------
  // Software registers
  // ------
  logic [2:0] cfg_q;
  logic [7:0] stat1_q;
  logic [7:0] stat2_q;
  logic       standby_q;
  logic       done_q;
  logic       no_plug_q;
  logic       timeout_q;
  logic       busy;
  logic [7:0] rd_mux;

  wire wr_cfg = sw_write && (sw_addr == wkh_pkg::SW_CONFIG);
  wire wr_cmd = sw_write && (sw_addr == wkh_pkg::SW_CMD);
  wire cmd_sb = wr_cmd && sw_wdata[wkh_pkg::CMD_STANDBY];
  wire cmd_wk = wr_cmd && sw_wdata[wkh_pkg::CMD_WAKE];
  wire pin_ev = (cfg_q[wkh_pkg::CFG_USE_WAKE] && !wake_f_q) ||
                (cfg_q[wkh_pkg::CFG_USE_INT] && !irq_f_q);         // [R5]
  wire auto_wk = cfg_q[wkh_pkg::CFG_ARMED] && standby_q && pin_ev; // [R5]

  // Read selection; unmapped addresses read zero.
  assign rd_mux =
    (sw_addr == wkh_pkg::SW_CONFIG) ? {5'h00, cfg_q} :
    (sw_addr == wkh_pkg::SW_STATUS) ?
      {2'h0, stat1_q[wkh_pkg::PLUG_BIT], timeout_q, no_plug_q, done_q,
       standby_q, busy} :
    (sw_addr == wkh_pkg::SW_STAT1)  ? stat1_q :
    (sw_addr == wkh_pkg::SW_STAT2)  ? stat2_q : 8'h00;

  // Configuration register and registered read data.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_q    <= 3'h0;
      sw_rdata <= 8'h00;
    end else begin
      if (wr_cfg) cfg_q <= sw_wdata[2:0];
      sw_rdata <= sw_read ? rd_mux : 8'h00;
    end
  end

  // ------
  // Sequencer
  // ------
  wkh_pkg::wkh_state_t state_q;
  logic [4:0]          pc_q;
  logic [7:0]          polls_q;
  wkh_pkg::wkh_step_t  cur;
  wkh_tmr_if #(.W(wkh_pkg::TMR_W)) tmr ();

  assign cur  = step_at(pc_q);
  assign busy = (state_q != wkh_pkg::S_IDLE);

  wire in_fetch = (state_q == wkh_pkg::S_FETCH);
  wire is_bus   = (cur.op == wkh_pkg::OP_WR) || (cur.op == wkh_pkg::OP_RD) ||
                  (cur.op == wkh_pkg::OP_POLL);
  wire acked    = (state_q == wkh_pkg::S_REQ) && dev_ack;
  wire poll_hit = dev_rdata[wkh_pkg::AUTO_DONE_BIT];
  wire poll_end = (polls_q == 8'(POLL_LIMIT - 1));
  wire plugged  = stat1_q[wkh_pkg::PLUG_BIT];
  wire start    = !busy && (cmd_sb || cmd_wk || auto_wk);

  assign tmr.load  = in_fetch && (cur.op == wkh_pkg::OP_WAIT);      // [R21]
  assign tmr.count = wait_len(cur.data[1:0]);

  wkh_timer #(.W(wkh_pkg::TMR_W)) u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .t     (tmr.tmr)
  );

  // Step engine: one step at a time.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= wkh_pkg::S_IDLE;
      pc_q    <= wkh_pkg::PC_STANDBY;
      polls_q <= 8'h00;
    end else begin
      case (state_q)
        wkh_pkg::S_IDLE: begin
          if (start) begin
            pc_q    <= cmd_sb ? wkh_pkg::PC_STANDBY : wkh_pkg::PC_WAKE;
            polls_q <= 8'h00;
            state_q <= wkh_pkg::S_FETCH;
          end
        end
        wkh_pkg::S_FETCH: begin
          if (is_bus) state_q <= wkh_pkg::S_REQ;                 // [R21]
          else if (cur.op == wkh_pkg::OP_WAIT) state_q <= wkh_pkg::S_TIMER;
          else if (cur.op == wkh_pkg::OP_END) state_q <= wkh_pkg::S_IDLE;
          else if (cur.op == wkh_pkg::OP_BRANCH && !plugged)
            state_q <= wkh_pkg::S_IDLE;                          // [R11]
          else state_q <= wkh_pkg::S_NEXT;
        end
        wkh_pkg::S_REQ: begin
          if (dev_ack) begin
            if (cur.op != wkh_pkg::OP_POLL || poll_hit) begin
              state_q <= wkh_pkg::S_NEXT;
            end else if (poll_end) begin
              state_q <= wkh_pkg::S_IDLE;
            end else begin
              polls_q <= polls_q + 8'h01;
              state_q <= wkh_pkg::S_FETCH;
            end
          end
        end
        wkh_pkg::S_TIMER: begin
          if (tmr.expired) state_q <= wkh_pkg::S_NEXT;           // [R21]
        end
        wkh_pkg::S_NEXT: begin
          pc_q    <= pc_q + 5'h01;
          state_q <= wkh_pkg::S_FETCH;
        end
        default: state_q <= wkh_pkg::S_IDLE;
      endcase
    end
  end

  // Device port fields, held until the acknowledge.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dev_req   <= 1'b0;
      dev_write <= 1'b0;
      dev_addr  <= 16'h0000;
      dev_wdata <= 8'h00;
    end else if (in_fetch && is_bus) begin
      dev_req   <= 1'b1;
      dev_write <= (cur.op == wkh_pkg::OP_WR);
      dev_addr  <= cur.addr;
      dev_wdata <= cur.data;
    end else if (acked) begin
      dev_req   <= 1'b0;
      dev_write <= 1'b0;
    end
  end

  // Captured status bytes and outcome flags.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat1_q      <= 8'h00;
      stat2_q      <= 8'h00;
      standby_q    <= 1'b0;
      done_q       <= 1'b0;
      no_plug_q    <= 1'b0;
      timeout_q    <= 1'b0;
      supply_en    <= 1'b0;
      ref_clock_en <= 1'b0;
    end else begin
      if (start) begin
        done_q    <= 1'b0;
        no_plug_q <= 1'b0;
        timeout_q <= 1'b0;
      end
      if (acked && dev_addr == wkh_pkg::DETECT_EVENT_STATUS_ONE)
        stat1_q <= dev_rdata;                                    // [R11]
      if (acked && dev_addr == wkh_pkg::DETECT_EVENT_STATUS_TWO)
        stat2_q <= dev_rdata;                                    // [R11]
      if (in_fetch && cur.op == wkh_pkg::OP_PWR) begin
        supply_en    <= 1'b1;                                    // [R6]
        ref_clock_en <= 1'b1;                                    // [R6]
      end
      if (in_fetch && cur.op == wkh_pkg::OP_END) begin
        standby_q <= (pc_q == wkh_pkg::PC_STANDBY + 5'h01);      // [R4]
        done_q    <= (pc_q != wkh_pkg::PC_STANDBY + 5'h01);
      end
      if (in_fetch && cur.op == wkh_pkg::OP_BRANCH && !plugged) begin
        standby_q <= 1'b1;
        no_plug_q <= 1'b1;
      end
      if (acked && cur.op == wkh_pkg::OP_POLL && !poll_hit && poll_end)
        timeout_q <= 1'b1;
      if (start && !cmd_sb) standby_q <= 1'b0;
    end
  end

endmodule : wkh_sequencer
`default_nettype wire

// [core/wkh_timer.sv]
// Down-counting wait timer that pulses once when its count runs out.
`timescale 1ns/1ps
`default_nettype none
module wkh_timer #(
  parameter int W = 24
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Timer control.
  wkh_tmr_if.tmr    t
);

  logic [W-1:0] cnt_q;
  logic         busy_q;
  logic         exp_q;
  wire          last = busy_q && (cnt_q == {{(W-1){1'b0}}, 1'b1});

  initial begin
    if (W < 2) $error("wkh_timer: width too small");
  end

  // Load, count down and flag the last cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      exp_q  <= 1'b0;
    end else begin
      exp_q <= last && !t.load;
      if (t.load) begin
        cnt_q  <= t.count;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q  <= cnt_q - 1'b1;
        busy_q <= !last;
      end
    end
  end

  assign t.busy    = busy_q;
  assign t.expired = exp_q;

endmodule : wkh_timer
`default_nettype wire

// [core/wkh_tmr_if.sv]
// Interface between the sequencer and its wait timer.
`timescale 1ns/1ps
`default_nettype none
interface wkh_tmr_if #(parameter int W = 24);
  logic         load;
  logic [W-1:0] count;
  logic         busy;
  logic         expired;
  modport ctrl (output load, output count, input busy, input expired);
  modport tmr  (input load, input count, output busy, output expired);
endinterface : wkh_tmr_if
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench of the wake and detect sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock, rst_n, sw_write, sw_read, dev_req, dev_write, dev_ack;
  logic        wake_n, irq_n, supply_en, ref_clock_en, wake_trig, slow;
  logic        done_en;
  logic [3:0]  sw_addr;
  logic [7:0]  sw_wdata, sw_rdata, dev_wdata, dev_rdata, stat1, stat2, d;
  logic [15:0] dev_addr;
  logic [31:0] seed;
  int          failures, samples_checked, i;
  logic [23:0] exp_wr [13] = '{24'h100900, 24'h1B71C0, 24'h1B755F,
    24'h1B71C1, 24'h1B71C0, 24'h1B759F, 24'h1101FE, 24'h110287, 24'h1F0686,
    24'h1B7407, 24'h131B01, 24'h112080, 24'h1120C0};
  // Runs as {by pin, plug seen, done reported}.
  logic [2:0]  plan [6] = '{3'b011, 3'b001, 3'b110, 3'b111, 3'b101, 3'b011};
  wkh_sequencer #(.REF_WAIT_CYC(2), .BIAS_WAIT_CYC(5), .POLL_LIMIT(2))
    u_wkh_sequencer (.clock(clock), .rst_n(rst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
    .sw_rdata(sw_rdata), .dev_req(dev_req), .dev_write(dev_write),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata), .wake_n(wake_n), .irq_n(irq_n),
    .supply_en(supply_en), .ref_clock_en(ref_clock_en));
  wkh_codec_model u_wkh_codec_model (.clock(clock), .rst_n(rst_n),
    .dev_req(dev_req), .dev_write(dev_write), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .wake_n(wake_n), .irq_n(irq_n), .wake_trig(wake_trig), .slow(slow),
    .done_en(done_en), .stat1(stat1), .stat2(stat2));
  // Clock of 100 ns period.
  always #50 clock = ~clock;
  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [23:0] seen, want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    sw_addr  <= a;
    sw_wdata <= v;
    sw_write <= 1'b1;
    @(posedge clock);
    sw_write <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge clock);
    sw_read <= 1'b0;
    @(negedge clock);
    v = sw_rdata;
  endtask : sw_rd
  // Waits for the run to start, then polls until busy clears.
  task automatic wait_idle();
    logic [7:0] st;
    st = 8'h01;
    for (int k = 0; k < 40 && dev_req !== 1'b1; k++) @(posedge clock);
    for (int k = 0; k < 3000 && st[0] !== 1'b0; k++)
      sw_rd(wkh_pkg::SW_STATUS, st);
    check("busy", 24'(st[0]), 24'h0);
  endtask : wait_idle
  task automatic go_standby();
    u_wkh_codec_model.log_q.delete();
    sw_wr(wkh_pkg::SW_CMD, 8'h01);
    wait_idle();
    check("clamp", u_wkh_codec_model.log_q[0][23:0],
      {wkh_pkg::HEADSET_CLAMP_CONTROL, wkh_pkg::VAL_CLAMP_OFF});
    sw_rd(wkh_pkg::SW_STATUS, d);
    check("standby", 24'(d[1]), 24'h1);
  endtask : go_standby
  // Expected {plug, timeout, no plug, done} of the status register.
  function automatic logic [3:0] exp_flags(input logic [2:0] p);
    return {p[1], p[1] & ~p[0], ~p[1], p[1] & p[0]};
  endfunction : exp_flags
  // Gap in cycles between two logged writes is at least n.
  function automatic logic gap_ok(input int a, input int n);
    return u_wkh_codec_model.log_q[a + 1][55:24] -
      u_wkh_codec_model.log_q[a][55:24] >= 32'(n);
  endfunction : gap_ok
  task automatic run_wake(input logic [2:0] p);
    logic [7:0] s1;
    s1 = 8'($random(seed));
    s1[6] = p[1];
    if (p[2]) begin
      go_standby();
      sw_wr(wkh_pkg::SW_CONFIG, 8'h05);
    end
    stat1   <= s1;
    stat2   <= 8'($random(seed));
    slow    <= seed[0];
    done_en <= p[0];
    u_wkh_codec_model.log_q.delete();
    if (p[2]) begin
      @(posedge clock) wake_trig <= 1'b1;
      @(posedge clock) wake_trig <= 1'b0;
    end else
      sw_wr(wkh_pkg::SW_CMD, 8'h02);
    wait_idle();
    sw_rd(wkh_pkg::SW_STATUS, d);
    check("flags", 24'(d[5:2]), 24'(exp_flags(p)));
    sw_rd(wkh_pkg::SW_STAT1, d);
    check("status one", 24'(d), 24'(s1));
    check("writes", 24'(u_wkh_codec_model.log_q.size()),
      p[1] ? 24'd13 : 24'd5);
    for (int k = 0; k < (p[1] ? 13 : 5); k++)
      check("write", u_wkh_codec_model.log_q[k][23:0], exp_wr[k]);
    check("copy wait", 24'(gap_ok(2, wkh_pkg::CYC_XFER)), 24'h1);
    if (p[1]) begin
      check("bias wait", 24'(gap_ok(9, 5)), 24'h1);
      check("arm wait", 24'(gap_ok(11, wkh_pkg::CYC_ARM)), 24'h1);
    end
    check("wake pin", 24'(wake_n), 24'h1);
    check("supplies", 24'({supply_en, ref_clock_en}), 24'h3);
    $display("test wake run %b finished", p);
  endtask : run_wake
  // ------
  // Main sequence and watchdog
  // ------
  initial begin
    {clock, rst_n, sw_write, sw_read, wake_trig, slow, done_en} = 7'h00;
    {sw_addr, sw_wdata, stat1, stat2} = 28'h0;
    seed = 32'hf7ec;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    sw_rd(wkh_pkg::SW_STATUS, d);
    check("status at reset", 24'(d), 24'h0);
    for (i = 5; i < 16; i++) begin
      sw_rd(4'(i), d);
      check("unmapped read", 24'(d), 24'h0);
    end
    $display("test register reads finished");
    for (i = 0; i < 6; i++)
      run_wake(plan[i]);
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// [tb/wkh_chk.sv]
// Port assertions of the wake and detect sequencer.
`timescale 1ns/1ps
`default_nettype none
module wkh_chk (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst_n,
  // Software read port.
  input wire logic        sw_read,
  input wire logic [7:0]  sw_rdata,
  // Device port and supplies.
  input wire logic        dev_req,
  input wire logic        dev_write,
  input wire logic [15:0] dev_addr,
  input wire logic [7:0]  dev_wdata,
  input wire logic        dev_ack,
  input wire logic        supply_en,
  input wire logic        ref_clock_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A write request is on the device port.
  wire logic wr = dev_req && dev_write;
  // ------
  // Sequences and checks
  // ------
  // An ended access other than a codec event status poll is followed by two quiet cycles.
  sequence s_quiet;
    !dev_req ##1 !dev_req;
  endsequence
  req_hold_a: assert property (dev_req && !dev_ack |=> dev_req
    && $stable(dev_addr) && $stable(dev_wdata)) else $error("request moved");
  ack_gap_a: assert property (dev_req && dev_ack &&
    dev_addr != 16'h1308 |=> s_quiet) else $error("request too soon");
  poll_gap_a: assert property (dev_req && dev_ack |=> !dev_req)
    else $error("request held after ack");
  clock_on_a: assert property (wr && dev_addr == 16'h1009 |->
    supply_en && ref_clock_en && dev_wdata == 8'h00) else $error("clock");
  supply_keep_a: assert property (supply_en |=>
    supply_en && ref_clock_en) else $error("supply dropped");
  wake_value_a: assert property (wr && dev_addr == 16'h1B71 |->
    dev_wdata inside {8'hC0, 8'hC1}) else $error("wake control value");
  mic_value_a: assert property (wr && dev_addr == 16'h1B75 |->
    dev_wdata inside {8'h5F, 8'h9F}) else $error("mic detect value");
  pdn_one_a: assert property (wr && dev_addr == 16'h1101 |->
    dev_wdata == 8'hFE) else $error("power down one value");
  pdn_two_a: assert property (wr && dev_addr == 16'h1102 |->
    dev_wdata == 8'h87) else $error("power down two value");
  conv_value_a: assert property (wr && dev_addr == 16'h1F06 |->
    dev_wdata == 8'h86) else $error("converter value");
  misc_value_a: assert property (wr && dev_addr == 16'h1B74 |->
    dev_wdata == 8'h07) else $error("misc detect value");
  mask_value_a: assert property (wr && dev_addr == 16'h131B |->
    dev_wdata == 8'h01) else $error("event mask value");
  detect_value_a: assert property (wr && dev_addr == 16'h1120 |->
    dev_wdata inside {8'h80, 8'hC0}) else $error("detect mode value");
  rdata_idle_a: assert property (!$past(sw_read) |-> sw_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : wkh_chk
bind wkh_sequencer wkh_chk u_chk (.clock(clock), .rst_n(rst_n),
  .sw_read(sw_read), .sw_rdata(sw_rdata), .dev_req(dev_req),
  .dev_write(dev_write), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_ack(dev_ack), .supply_en(supply_en), .ref_clock_en(ref_clock_en));
`default_nettype wire

// [tb/wkh_codec_model.sv]
// Behavioural codec answering the sequencer's device port.
`timescale 1ns/1ps
`default_nettype none
module wkh_codec_model (
  // Clock and reset; clock is the bypass master clock.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Device control port.
  input  wire logic        dev_req,
  input  wire logic        dev_write,
  input  wire logic [15:0] dev_addr,
  input  wire logic [7:0]  dev_wdata,
  output logic             dev_ack,
  output logic      [7:0]  dev_rdata,
  // Pins and scenario controls.
  output logic             wake_n,
  output logic             irq_n,
  input  wire logic        wake_trig,
  input  wire logic        slow,
  input  wire logic        done_en,
  input  wire logic [7:0]  stat1,
  input  wire logic [7:0]  stat2
);
  logic [1:0]  lat_q;
  logic        done_q;
  logic [31:0] cyc_q;
  logic [55:0] log_q[$];
  // Status registers; the done flag sits in bit 1 of the codec status.
  wire logic [7:0] rd_val = (dev_addr == 16'h1309) ? stat1 :
    (dev_addr == 16'h130A) ? stat2 : {6'h00, done_q, 1'b0};
  // Done raises the unmasked interrupt pin.
  assign irq_n = ~done_q;
  // Accesses end after zero or three wait cycles; idle data keeps toggling.
  always @(posedge clock) begin
    dev_ack   <= 1'b0;
    dev_rdata <= ~dev_rdata;
    cyc_q     <= cyc_q + 32'h1;
    if (!rst_n) begin
      lat_q     <= 2'h0;
      done_q    <= 1'b0;
      wake_n    <= 1'b1;
      cyc_q     <= 32'h0;
      dev_rdata <= 8'h5A;
    end else begin
      if (wake_trig)
        wake_n <= 1'b0;
      if (dev_req && !dev_ack && lat_q != 2'h0)
        lat_q <= lat_q - 2'h1;
      else if (dev_req && !dev_ack) begin
        dev_ack <= 1'b1;
        lat_q   <= slow ? 2'h3 : 2'h0;
        if (!dev_write)
          dev_rdata <= rd_val;
        else begin
          log_q.push_back({cyc_q, dev_addr, dev_wdata});
          if (dev_addr == 16'h1B71 && dev_wdata[0])
            wake_n <= 1'b1;
          if (dev_addr == 16'h1120)
            done_q <= done_en && dev_wdata == 8'hC0;
        end
      end
    end
  end
endmodule : wkh_codec_model
`default_nettype wire
